// ### pkg/ssc_pkg.sv
// Package: constants and types for the station switch configuration loader
package ssc_pkg;
   // Switch widths
   localparam int SSC_ROT_W = 4;
   localparam int SSC_DIP_W = 4;
   // DIP position indices
   localparam int SSC_DIP_RATE = 0;
   localparam int SSC_DIP_LEN = 1;
   localparam int SSC_DIP_BASE = 2;
   localparam int SSC_DIP_RSVD = 3;
   // Address bases and lengths
   localparam logic [7:0] SSC_BASE_LO = 8'h40;
   localparam logic [7:0] SSC_BASE_HI = 8'h50;
   localparam logic [5:0] SSC_LEN_SHORT = 6'h11;
   localparam logic [5:0] SSC_LEN_LONG = 6'h20;
   // Link rates in Mbps
   localparam logic [3:0] SSC_RATE_SLOW_MBPS = 4'h4;
   localparam logic [3:0] SSC_RATE_FAST_MBPS = 4'hA;
   // Factory switch positions
   localparam logic [3:0] SSC_FACTORY_ROT = 4'h1;
   localparam logic [3:0] SSC_FACTORY_DIP = 4'h3;
   // Register byte offsets
   localparam logic [3:0] SSC_REG_STATUS = 4'h0;
   localparam logic [3:0] SSC_REG_SWITCH = 4'h4;
   localparam logic [3:0] SSC_REG_CTRL = 4'h8;
   // Status field positions
   localparam int SSC_ST_ADDR_LSB = 0;
   localparam int SSC_ST_LEN_LSB = 8;
   localparam int SSC_ST_FAST = 16;
   localparam int SSC_ST_ADDR_OK = 17;
   localparam int SSC_ST_LOADED = 18;
   localparam int SSC_ST_RSVD_BAD = 19;
   // Bus answers
   localparam logic [1:0] SSC_RESP_OKAY = 2'h0;
   localparam logic [1:0] SSC_RESP_SLVERR = 2'h2;
   // Loader states
   typedef enum logic [1:0] {
      SSC_ST_IDLE = 2'b00,
      SSC_ST_SAMPLE = 2'b01,
      SSC_ST_HOLD = 2'b10
   } ssc_state_t;
endpackage : ssc_pkg

// ### pkg/ssc_cfg_if.sv
// Interface: held switch image into the decoder and decoded settings back to the top
`timescale 1ns/100ps
interface ssc_cfg_if;
   logic [3:0] rot; // Rotary value
   logic [3:0] dip; // DIP positions
   logic fast; // Fast rate chosen
   logic [5:0] len; // Bytes per frame
   logic [7:0] addr; // Station address
   logic addr_ok; // Address enabled
   modport dec (input rot, input dip, output fast, output len, output addr, output addr_ok);
   modport top (output rot, output dip, input fast, input len, input addr, input addr_ok);
endinterface : ssc_cfg_if

// ### verilog/ssc_decode.sv
// Module: combinational decode of switch positions into link settings
`timescale 1ns/100ps
module ssc_decode import ssc_pkg::*; (
   ssc_cfg_if.dec cfg
);
   // Rate from first position
   assign cfg.fast = cfg.dip[SSC_DIP_RATE]; // R1
   // Long frame only at fast rate
   assign cfg.len = (cfg.fast && cfg.dip[SSC_DIP_LEN]) ? SSC_LEN_LONG : SSC_LEN_SHORT; // R2 R3
   // Base plus rotary value
   assign cfg.addr = (cfg.dip[SSC_DIP_BASE] ? SSC_BASE_HI : SSC_BASE_LO) + {4'h0, cfg.rot}; // R4
   // Low base with zero rotary is disabled
   assign cfg.addr_ok = cfg.dip[SSC_DIP_BASE] || (cfg.rot != 4'h0); // R5
endmodule : ssc_decode

// ### verilog/ssc_station_switch_config.sv
// Module: switch sampling, held link settings and AXI4-Lite status port
// Functional notes
// R1: DIP position one selects 4 or 10 Mbps
// R2: DIP position two selects 17 or 32 bytes
// R3: Slow rate forces 17-byte frames
// R4: Address is 40H or 50H plus rotary
// R5: Low base with rotary zero disables address
// R6: Factory switches give fast, 32 bytes, 41H
// R7: Changes apply only after a power cycle
// R8: Fourth DIP position must stay off
// R9: Legacy networks need positions one, two off
// R10: Sample once after reset, hold until power cycle
`timescale 1ns/100ps
module ssc_station_switch_config import ssc_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] rotary_address_switch,
   input wire logic [3:0] dip_config_switch,
   output logic link_fast,
   output logic [3:0] link_rate_mbps,
   output logic [5:0] frame_bytes,
   output logic [7:0] station_addr,
   output logic station_addr_valid,
   output logic config_loaded,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   ssc_cfg_if cfg (); // Decoder link
   ssc_state_t state; // Loader state
   ssc_state_t next_state; // Loader next state
   logic [3:0] rot_q; // Sampled rotary
   logic [3:0] dip_q; // Sampled DIP
   logic use_factory; // Software asks for factory settings
   logic aw_held; // Write address captured
   logic w_held; // Write data captured
   logic [3:0] aw_addr; // Captured write address
   logic [31:0] w_data; // Captured write data
   logic [3:0] w_strb; // Captured strobes

   // Decoder sees the held switch image only, so live moves never leak through
   assign cfg.rot = rot_q; // R7
   assign cfg.dip = dip_q;
   ssc_decode u_dec (
      .cfg(cfg)
   );

   // Loader sequence: idle, one sample, hold forever
   always_comb begin
      case (state)
         SSC_ST_IDLE: next_state = SSC_ST_SAMPLE;
         SSC_ST_SAMPLE: next_state = SSC_ST_HOLD;
         SSC_ST_HOLD: next_state = SSC_ST_HOLD; // R10
         default: next_state = SSC_ST_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= SSC_ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Switch capture; reset value is the factory image until the sample lands
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rot_q <= SSC_FACTORY_ROT; // R6
         dip_q <= SSC_FACTORY_DIP; // R6
      end else if (state == SSC_ST_SAMPLE) begin
         // Taken once; later switch moves need a new reset
         if (use_factory) begin
            rot_q <= SSC_FACTORY_ROT; // R6
            dip_q <= SSC_FACTORY_DIP;
         end else begin
            rot_q <= rotary_address_switch; // R10
            dip_q <= dip_config_switch; // R10
         end
      end
   end

   // Held outputs, registered from the decoder
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         link_fast <= 1'b0;
         link_rate_mbps <= SSC_RATE_SLOW_MBPS;
         frame_bytes <= SSC_LEN_SHORT;
         station_addr <= 8'h00;
         station_addr_valid <= 1'b0;
         config_loaded <= 1'b0;
      end else if (state == SSC_ST_HOLD && !config_loaded) begin
         // Published once; held until the next reset
         link_fast <= cfg.fast; // R1
         link_rate_mbps <= cfg.fast ? SSC_RATE_FAST_MBPS : SSC_RATE_SLOW_MBPS; // R1
         frame_bytes <= cfg.len; // R2 R3
         station_addr <= cfg.addr_ok ? cfg.addr : 8'h00; // R4 R5
         station_addr_valid <= cfg.addr_ok; // R5
         config_loaded <= 1'b1; // R7
      end
   end

   // Write channel capture; address and data in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 4'h0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
      end
   end

   // Ready while the slot is free and no response is pending
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;

   // Write response and control register; writes only set a read-back bit that reset clears before the next sample
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= SSC_RESP_OKAY;
         use_factory <= 1'b0;
      end else if (s_axi_bvalid) begin
         if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end else if (aw_held && w_held) begin
         s_axi_bvalid <= 1'b1;
         if (aw_addr == SSC_REG_CTRL) begin
            s_axi_bresp <= SSC_RESP_OKAY;
            if (w_strb[0]) begin
               // Held config is frozen; reset clears this bit before the next sample, so it only reads back
               use_factory <= w_data[0]; // R7
            end
         end else if (aw_addr == SSC_REG_STATUS || aw_addr == SSC_REG_SWITCH) begin
            s_axi_bresp <= SSC_RESP_OKAY; // Read-only, write ignored
         end else begin
            s_axi_bresp <= SSC_RESP_SLVERR; // Unmapped
         end
      end
   end

   // Read channel
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= SSC_RESP_OKAY;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end else if (s_axi_arvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= SSC_RESP_OKAY;
         s_axi_rdata <= 32'h0000_0000;
         case (s_axi_araddr)
            SSC_REG_STATUS: begin
               s_axi_rdata[SSC_ST_ADDR_LSB +: 8] <= station_addr;
               s_axi_rdata[SSC_ST_LEN_LSB +: 6] <= frame_bytes;
               s_axi_rdata[SSC_ST_FAST] <= link_fast;
               s_axi_rdata[SSC_ST_ADDR_OK] <= station_addr_valid;
               s_axi_rdata[SSC_ST_LOADED] <= config_loaded;
               // Flags a reserved position left on
               s_axi_rdata[SSC_ST_RSVD_BAD] <= dip_q[SSC_DIP_RSVD]; // R8
            end
            SSC_REG_SWITCH: begin
               // Live and held switches, to show pending changes
               s_axi_rdata[3:0] <= rotary_address_switch;
               s_axi_rdata[7:4] <= dip_config_switch;
               s_axi_rdata[11:8] <= rot_q;
               s_axi_rdata[15:12] <= dip_q;
            end
            SSC_REG_CTRL: begin
               s_axi_rdata[0] <= use_factory;
            end
            default: begin
               s_axi_rresp <= SSC_RESP_SLVERR;
            end
         endcase
      end
   end
endmodule : ssc_station_switch_config

// ### bench/ssc_switch_panel.sv
// Partner model: the switch panel that the installer sets
`timescale 1ns/100ps
module ssc_switch_panel (
   input wire logic [3:0] set_rot,
   input wire logic [3:0] set_dip,
   input wire logic legacy,
   output logic [3:0] rot,
   output logic [3:0] dip
);
   // Rotary passed as set
   assign rot = set_rot;
   // Reserved position never moved, whatever was asked
   assign dip[3] = 1'b0;
   // Slow network joins need both rate and length off
   assign dip[1:0] = legacy ? 2'b00 : set_dip[1:0];
   // Base position passed as set
   assign dip[2] = set_dip[2];
endmodule : ssc_switch_panel

// ### bench/ssc_station_switch_config_assertions.sv
// Checker: port properties of the switch loader
`timescale 1ns/100ps
module ssc_chk import ssc_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] rotary_address_switch,
   input wire logic [3:0] dip_config_switch,
   input wire logic link_fast,
   input wire logic [3:0] link_rate_mbps,
   input wire logic [5:0] frame_bytes,
   input wire logic [7:0] station_addr,
   input wire logic station_addr_valid,
   input wire logic config_loaded
);
   // One domain, reset disables all
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Load follows release within a few edges
   sequence s_rel; $rose(aresetn); endsequence
   sequence s_load; !config_loaded ##[1:4] config_loaded; endsequence
   property p_load; s_rel |-> s_load; endproperty
   a_load: assert property (p_load) else $error("load not seen after release");
   // Held address, length and rate flag never move until next reset
   property p_keep; config_loaded |=> config_loaded && $stable(station_addr) && $stable(frame_bytes)
      && $stable(link_fast); endproperty
   a_keep: assert property (p_keep) else $error("held settings changed");
   property p_rate; $rose(config_loaded) |-> link_fast == dip_config_switch[SSC_DIP_RATE]; endproperty
   a_rate: assert property (p_rate) else $error("rate not from first position");
   property p_mbps; config_loaded |-> link_rate_mbps == (link_fast ? 4'hA : 4'h4); endproperty
   a_mbps: assert property (p_mbps) else $error("rate value wrong");
   property p_len; $rose(config_loaded) |-> frame_bytes == ((dip_config_switch[0] && dip_config_switch[1])
      ? 6'h20 : 6'h11); endproperty
   a_len: assert property (p_len) else $error("frame length wrong");
   property p_slow; config_loaded && !link_fast |-> frame_bytes == 6'h11; endproperty
   a_slow: assert property (p_slow) else $error("slow rate not forcing 17");
   property p_addr; $rose(config_loaded) && station_addr_valid |-> station_addr ==
      (dip_config_switch[2] ? 8'h50 : 8'h40) + {4'h0, rotary_address_switch}; endproperty
   a_addr: assert property (p_addr) else $error("address sum wrong");
   property p_dis; $rose(config_loaded) |-> station_addr_valid == (dip_config_switch[2]
      || rotary_address_switch != 4'h0) && (station_addr_valid || station_addr == 8'h00); endproperty
   a_dis: assert property (p_dis) else $error("disabled address wrong");
endmodule : ssc_chk
bind ssc_station_switch_config ssc_chk i_chk (.aclk(aclk), .aresetn(aresetn),
   .rotary_address_switch(rotary_address_switch), .dip_config_switch(dip_config_switch),
   .link_fast(link_fast), .link_rate_mbps(link_rate_mbps), .frame_bytes(frame_bytes),
   .station_addr(station_addr), .station_addr_valid(station_addr_valid), .config_loaded(config_loaded));

// ### bench/tb.sv
// Testbench: switch cases, hold check and register reads
`timescale 1ns/100ps
module tb import ssc_pkg::*;;
   logic aclk = 1'b0, aresetn = 1'b0, legacy = 1'b0, fast, ok, loaded;
   logic [3:0] set_rot = 4'h0, set_dip = 4'h0, rot, dip, mbps, awaddr = 4'h0, araddr = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [31:0] wdata = 32'h0, rdata;
   logic [5:0] nbytes;
   logic [7:0] addr;
   logic [1:0] bresp, rresp;
   logic [7:0] cfg [9] = '{8'h00, 8'hF1, 8'h22, 8'h13, 8'h04, 8'hA5, 8'h76, 8'hFB, 8'h13};
   int bad_count = 0, tests_run = 0, cyc = 0;
   // Clock at 4 ns
   initial forever #2 aclk = ~aclk;
   ssc_switch_panel i_ssc_switch_panel (.set_rot(set_rot), .set_dip(set_dip), .legacy(legacy), .rot(rot), .dip(dip));
   ssc_station_switch_config i_ssc_station_switch_config (.aclk(aclk), .aresetn(aresetn),
      .rotary_address_switch(rot), .dip_config_switch(dip), .link_fast(fast), .link_rate_mbps(mbps),
      .frame_bytes(nbytes), .station_addr(addr), .station_addr_valid(ok), .config_loaded(loaded),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));
   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      tests_run++;
      if (seen !== want) begin
         bad_count++;
         $display("Error %0t: saw %h want %h", $time, seen, want);
      end
   endtask : check
   // Verdict, reached from the end or the timeout
   task automatic test_done();
      $display("compares %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : test_done
   // Bus read; ready sampled at the edge itself
   task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      @(posedge aclk iff arready);
      arvalid <= 1'b0;
      @(posedge aclk iff rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd
   // Bus write; address and data released independently
   task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      fork
         begin @(posedge aclk iff awready); awvalid <= 1'b0; end
         begin @(posedge aclk iff wready); wvalid <= 1'b0; end
      join
      @(posedge aclk iff bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask : wr
   // Power cycle with new switch positions
   task automatic boot(input logic [7:0] c, input logic lg);
      @(posedge aclk);
      aresetn <= 1'b0;
      set_rot <= c[7:4];
      set_dip <= c[3:0];
      legacy <= lg;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk iff loaded);
   endtask : boot
   // Status word worked out from switch positions
   function automatic logic [31:0] exp_st(input logic [3:0] r, input logic [3:0] d);
      logic [7:0] a;
      a = (d[2] ? 8'h50 : 8'h40) + {4'h0, r};
      if (!d[2] && r == 4'h0) a = 8'h00;
      return {13'h0, 1'b1, a != 8'h00, d[0], 2'b00, (d[0] && d[1]) ? 6'h20 : 6'h11, a};
   endfunction : exp_st
   // Cut a hang short
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 5000) begin
         bad_count++;
         test_done();
      end
   end
   initial begin
      logic [31:0] s, e;
      logic [1:0] r;
      logic [3:0] hd; // DIP image the panel shows at boot
      for (int i = 0; i < 9; i++) begin
         boot(cfg[i], i == 8);
         // Last case is the slow network join
         hd = (i == 8) ? (cfg[i][3:0] & 4'h4) : (cfg[i][3:0] & 4'h7);
         e = exp_st(cfg[i][7:4], hd);
         // Held pins carry the same settings as the status word
         check({13'h0, loaded, ok, fast, 2'b00, nbytes, addr}, e);
         check({28'h0, mbps}, {28'h0, e[SSC_ST_FAST] ? SSC_RATE_FAST_MBPS : SSC_RATE_SLOW_MBPS});
         rd(SSC_REG_STATUS, s, r);
         check(s, e);
         if (i == 3) check({24'h0, addr}, 32'h41);
         // Move switches while running; nothing may change
         set_rot <= ~set_rot;
         set_dip <= ~set_dip;
         repeat (4) @(posedge aclk);
         // Held image stays, live image follows the panel
         rd(SSC_REG_SWITCH, s, r);
         check(s, {16'h0, hd, cfg[i][7:4], dip, rot});
         rd(SSC_REG_STATUS, s, r);
         check(s, e);
         $display("case %0d done", i);
      end
      rd(4'hC, s, r);
      check({30'h0, r}, {30'h0, SSC_RESP_SLVERR});
      wr(SSC_REG_STATUS, 32'hFFFF_FFFF, r);
      check({30'h0, r}, {30'h0, SSC_RESP_OKAY});
      // Factory request only reads back; the running settings stay frozen
      wr(SSC_REG_CTRL, 32'h0000_0001, r);
      check({30'h0, r}, {30'h0, SSC_RESP_OKAY});
      rd(SSC_REG_CTRL, s, r);
      check(s, 32'h0000_0001);
      // Unmapped write is refused
      wr(4'hC, 32'h0000_0001, r);
      check({30'h0, r}, {30'h0, SSC_RESP_SLVERR});
      rd(SSC_REG_STATUS, s, r);
      check(s, e);
      $display("bus case done");
      test_done();
   end
endmodule : tb
